/* File: chs_defines.svh */
`ifndef CHS_DEFINES_SVH
`define CHS_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CHS_OFF_MODE 12'h000
`define CHS_OFF_THRESH 12'h004
`define CHS_OFF_LEVEL 12'h008
`define CHS_OFF_STATUS 12'h00c
`define CHS_OFF_MASK 12'h010

// ----------------------------------------
// register selects after decode
// ----------------------------------------
`define CHS_SEL_NONE 3'h0
`define CHS_SEL_MODE 3'h1
`define CHS_SEL_THRESH 3'h2
`define CHS_SEL_LEVEL 3'h3
`define CHS_SEL_STATUS 3'h4
`define CHS_SEL_MASK 3'h5

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define CHS_NFLAGS 6
`define CHS_CNT_W 10
`define CHS_FIFO_DEPTH 512
`define CHS_NF_LSB 0
`define CHS_NE_LSB 16
`define CHS_MODE_RST 2'h2
`define CHS_NF_RST 10'h1c0
`define CHS_NE_RST 10'h040
`define CHS_MASK_RST 6'h00

`endif

/* File: chs_pkg.sv */
`include "chs_defines.svh"

package chs_pkg;

    // bit 0 first: halt, service, fault, last word, stats, sync error
    typedef struct packed {
        logic sync_fail;
        logic stats;
        logic last;
        logic fault;
        logic service;
        logic halt;
    } chs_flags_type;

    typedef struct packed {
        logic irq_high;
        logic encode;
    } chs_mode_type;

    // events and levels from the codec core
    typedef struct packed {
        logic [`CHS_CNT_W-1:0] fifo_count;
        logic overflow;
        logic underflow;
        logic stats_done;
        logic stats_taken;
        logic last_loaded;
        logic host_fifo_read;
        logic sync_fail;
    } chs_core_type;

endpackage : chs_pkg

/* File: chs_status_irq.sv */
// What this block does
// - halt high: empty encoding, full decoding
// - status levels readable in level register
// - stats ready raised after statistics refresh
// - stats ready event once per field
// - last code flags final word next read
// - interrupt from any enabled condition
// - interrupt polarity chosen in mode register
// - reset returns all registers to defaults
// - fault high on overflow/underflow, mirrored
// - service high nearly full/nearly empty
`include "chs_defines.svh"

module chs_status_irq #(
    parameter int DEPTH = `CHS_FIFO_DEPTH
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // codec core
    input wire chs_pkg::chs_core_type core,
    // status pins
    output logic fifo_halt_out,
    output logic fifo_service_out,
    output logic fifo_fault_out,
    output logic statistics_ready_out,
    output logic last_code_word,
    output logic sync_fail_out,
    output logic host_irq_out
);
    import chs_pkg::*;

    localparam logic [`CHS_CNT_W-1:0] FULL_CNT = `CHS_CNT_W'(DEPTH);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic [2:0] reg_sel(input logic [11:0] a);
        logic [2:0] s;
        s = `CHS_SEL_NONE;
        if (a == `CHS_OFF_MODE) begin
            s = `CHS_SEL_MODE;
        end else if (a == `CHS_OFF_THRESH) begin
            s = `CHS_SEL_THRESH;
        end else if (a == `CHS_OFF_LEVEL) begin
            s = `CHS_SEL_LEVEL;
        end else if (a == `CHS_OFF_STATUS) begin
            s = `CHS_SEL_STATUS;
        end else if (a == `CHS_OFF_MASK) begin
            s = `CHS_SEL_MASK;
        end
        return s;
    endfunction : reg_sel

    // ----------------------------------------
    // bus slave state
    // ----------------------------------------
    logic take;
    logic wr_fire;
    logic [2:0] wsel;
    logic vld_ff, nxt_vld;
    logic wr_ff, nxt_wr;
    logic [11:0] addr_ff, nxt_addr;
    logic [31:0] rdata_ff, nxt_rdata;

    chs_mode_type mode_ff, nxt_mode;
    logic [`CHS_CNT_W-1:0] nf_ff, nxt_nf;
    logic [`CHS_CNT_W-1:0] ne_ff, nxt_ne;
    chs_flags_type mask_ff, nxt_mask;
    chs_flags_type status_ff, nxt_status;
    chs_flags_type level_ff, nxt_level;
    chs_flags_type w1c;
    logic irq_ff, nxt_irq;

    assign take = hsel && hready && htrans[1];
    assign wr_fire = vld_ff && wr_ff;
    assign wsel = reg_sel(addr_ff);

    // zero wait states, errors never raised
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;

    always_comb begin
        nxt_vld = take;
        nxt_wr = take && hwrite;
        nxt_addr = take ? haddr[11:0] : addr_ff;
        nxt_rdata = rdata_ff;
        if (take && !hwrite) begin
            nxt_rdata = 32'h0000_0000;
            case (reg_sel(haddr[11:0]))
                `CHS_SEL_MODE: nxt_rdata[1:0] = mode_ff;
                `CHS_SEL_THRESH: begin
                    nxt_rdata[`CHS_NF_LSB +: `CHS_CNT_W] = nf_ff;
                    nxt_rdata[`CHS_NE_LSB +: `CHS_CNT_W] = ne_ff;
                end
                `CHS_SEL_LEVEL: nxt_rdata[`CHS_NFLAGS-1:0] = level_ff;
                `CHS_SEL_STATUS: nxt_rdata[`CHS_NFLAGS-1:0] = status_ff;
                `CHS_SEL_MASK: nxt_rdata[`CHS_NFLAGS-1:0] = mask_ff;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_comb begin
        nxt_mode = mode_ff;
        nxt_nf = nf_ff;
        nxt_ne = ne_ff;
        nxt_mask = mask_ff;
        w1c = '0;
        if (wr_fire) begin
            if (wsel == `CHS_SEL_MODE) begin
                nxt_mode = hwdata[1:0];
            end else if (wsel == `CHS_SEL_THRESH) begin
                nxt_nf = hwdata[`CHS_NF_LSB +: `CHS_CNT_W];
                nxt_ne = hwdata[`CHS_NE_LSB +: `CHS_CNT_W];
            end else if (wsel == `CHS_SEL_MASK) begin
                nxt_mask = hwdata[`CHS_NFLAGS-1:0];
            end else if (wsel == `CHS_SEL_STATUS) begin
                w1c = hwdata[`CHS_NFLAGS-1:0];
            end
        end
    end

    // ----------------------------------------
    // condition levels
    // ----------------------------------------
    always_comb begin
        nxt_level = level_ff;
        // encode drains the fifo to the host, decode fills it
        if (mode_ff.encode) begin
            nxt_level.halt = (core.fifo_count == '0);
            nxt_level.service = (core.fifo_count >= nf_ff);
            nxt_level.fault = core.overflow;
        end else begin
            nxt_level.halt = (core.fifo_count >= FULL_CNT);
            nxt_level.service = (core.fifo_count <= ne_ff);
            nxt_level.fault = core.underflow;
        end
        // set wins over the consuming event
        if (core.stats_done) begin
            nxt_level.stats = 1'b1;
        end else if (core.stats_taken) begin
            nxt_level.stats = 1'b0;
        end
        if (core.last_loaded) begin
            nxt_level.last = 1'b1;
        end else if (core.host_fifo_read) begin
            nxt_level.last = 1'b0;
        end
        nxt_level.sync_fail = core.sync_fail;
    end

    // ----------------------------------------
    // sticky status and interrupt
    // ----------------------------------------
    always_comb begin
        // a live condition re-sets its bit in the same cycle as a clear
        nxt_status = (status_ff & ~w1c) | level_ff;
        nxt_irq = (|(status_ff & mask_ff)) ~^ mode_ff.irq_high;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vld_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 12'h000;
            rdata_ff <= 32'h0000_0000;
            mode_ff <= `CHS_MODE_RST;
            nf_ff <= `CHS_NF_RST;
            ne_ff <= `CHS_NE_RST;
            mask_ff <= `CHS_MASK_RST;
            status_ff <= '0;
            level_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            vld_ff <= nxt_vld;
            wr_ff <= nxt_wr;
            addr_ff <= nxt_addr;
            rdata_ff <= nxt_rdata;
            mode_ff <= nxt_mode;
            nf_ff <= nxt_nf;
            ne_ff <= nxt_ne;
            mask_ff <= nxt_mask;
            status_ff <= nxt_status;
            level_ff <= nxt_level;
            irq_ff <= nxt_irq;
        end
    end

    assign fifo_halt_out = level_ff.halt;
    assign fifo_service_out = level_ff.service;
    assign fifo_fault_out = level_ff.fault;
    assign statistics_ready_out = level_ff.stats;
    assign last_code_word = level_ff.last;
    assign sync_fail_out = level_ff.sync_fail;
    assign host_irq_out = irq_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_level_read;
        take && !hwrite && (haddr[11:0] == `CHS_OFF_LEVEL);
    endsequence

    sequence s_read_data;
        ##1 hrdata[`CHS_NFLAGS-1:0] == $past(level_ff);
    endsequence

    sequence s_stats_event;
        core.stats_done ##1 statistics_ready_out;
    endsequence

    a_halt_encode: assert property (
        (mode_ff.encode && core.fifo_count == '0) |=> fifo_halt_out
    ) else $error("halt not raised on empty fifo while encoding");

    a_halt_decode: assert property (
        (!mode_ff.encode && core.fifo_count < FULL_CNT) |=> !fifo_halt_out
    ) else $error("halt raised on non-full fifo while decoding");

    a_level_mirror: assert property (
        s_level_read |-> s_read_data
    ) else $error("level register differs from status pins");

    a_status_sticky: assert property (
        (|level_ff) |=> ((status_ff & $past(level_ff)) == $past(level_ff))
    ) else $error("live condition missing from sticky status");

    a_stats_ready: assert property (
        s_stats_event
        or (!core.stats_done)
    ) else $error("stats ready not raised after refresh");

    a_stats_hold: assert property (
        (statistics_ready_out && !core.stats_taken) |=> statistics_ready_out
    ) else $error("stats ready dropped without being taken");

    a_last_clear: assert property (
        (last_code_word && core.host_fifo_read && !core.last_loaded)
        |=> !last_code_word ##1 (last_code_word == $past(core.last_loaded))
    ) else $error("last code flag not cleared by the final read");

    a_irq_any: assert property (
        (mode_ff.irq_high && (status_ff & mask_ff) != '0) |=> host_irq_out
    ) else $error("enabled condition did not raise the interrupt");

    a_irq_polarity: assert property (
        ((status_ff & mask_ff) == '0 && $stable(mode_ff)) [*2]
        |-> host_irq_out == !mode_ff.irq_high
    ) else $error("idle interrupt level has wrong polarity");

    a_fault_encode: assert property (
        (mode_ff.encode && core.overflow) |=> fifo_fault_out ##1 status_ff.fault
    ) else $error("overflow not shown as fault");

    a_service_decode: assert property (
        (!mode_ff.encode && core.fifo_count <= ne_ff) |=> fifo_service_out
    ) else $error("nearly empty fifo gave no service request");

    a_service_encode: assert property (
        (mode_ff.encode && core.fifo_count >= nf_ff) |=> fifo_service_out
    ) else $error("nearly full fifo gave no service request");

    a_halt_full: assert property (
        (!mode_ff.encode && core.fifo_count >= FULL_CNT) |=> fifo_halt_out
    ) else $error("halt not raised on full fifo while decoding");

    a_fault_decode: assert property (
        (!mode_ff.encode && core.underflow) |=> fifo_fault_out ##1 status_ff.fault
    ) else $error("underflow not shown as fault");

    a_last_set: assert property (
        core.last_loaded |=> last_code_word
    ) else $error("last code flag not raised for final word");

    a_irq_idle: assert property (
        (mode_ff.irq_high && (status_ff & mask_ff) == '0) |=> !host_irq_out
    ) else $error("interrupt raised with no enabled condition");

    a_sync_mirror: assert property (
        core.sync_fail |=> sync_fail_out
    ) else $error("sync error not shown on its pin");

    a_mode_write: assert property (
        (wr_fire && wsel == `CHS_SEL_MODE) |=> (mode_ff == $past(hwdata[1:0]))
    ) else $error("mode write did not land");

endmodule : chs_status_irq

/* File: chs_core_model.sv */
// ----------------------------------------
// codec core side: fifo level and events
// ----------------------------------------
module chs_core_model (
    // clock
    input wire logic hclk,
    // events toward the block
    output chs_pkg::chs_core_type core
);
    timeunit 1ns;
    timeprecision 1ps;
    import chs_pkg::*;

    // mid-range level so that no fifo flag is up at rest
    initial core = {10'h100, 7'h00};

    task drive(input logic [9:0] cnt, input logic [6:0] fl);
        @(posedge hclk);
        core <= {cnt, fl};
    endtask : drive

    // single-cycle event, then back to quiet
    task pulse(input logic [9:0] cnt, input logic [6:0] fl);
        drive(cnt, fl);
        drive(cnt, 7'h00);
    endtask : pulse
endmodule : chs_core_model

/* File: chs_status_irq_bench.sv */
module chs_status_irq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import chs_pkg::*;

    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic halt, service, fault, stats, last, sync, irq;
    chs_core_type core;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    chs_core_model i_core (.hclk(hclk), .core(core));
    chs_status_irq i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .core(core), .fifo_halt_out(halt), .fifo_service_out(service),
        .fifo_fault_out(fault), .statistics_ready_out(stats), .last_code_word(last),
        .sync_fail_out(sync), .host_irq_out(irq));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // all tests together need well under a thousand cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task tk(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : tk

    // one single word transfer; read data kept in rd
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    task rchk(input string what, input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(what, rd, e);
    endtask : rchk

    // back to decode, quiet level, status cleared
    task rest;
        ahb(1'b1, 32'h0, 32'h2);
        i_core.drive(10'h100, 7'h00);
        tk(2);
        ahb(1'b1, 32'hc, 32'h3f);
    endtask : rest

    task svc(input logic [31:0] m, input logic [9:0] c, input logic e);
        ahb(1'b1, 32'h0, m);
        i_core.drive(c, 7'h00);
        tk(2);
        chk("service", 32'(service), 32'(e));
    endtask : svc

    // ----------------------------------------
    // tests
    // ----------------------------------------
    task t_reset;
        chk("hresp", 32'(hresp), 32'h0);
        chk("hreadyout", 32'(hreadyout), 32'h1);
        rchk("mode", 32'h0, 32'h2);
        rchk("thresh", 32'h4, 32'h004001c0);
        rchk("mask", 32'h10, 32'h0);
        rchk("status", 32'hc, 32'h0);
        rchk("unmapped", 32'h14, 32'h0);
        ahb(1'b1, 32'h8, 32'h3f);
        rchk("level_ro", 32'h8, 32'h0);
        $display("t_reset done");
    endtask : t_reset

    task t_halt;
        i_core.drive(10'h200, 7'h00);
        tk(2);
        chk("halt_dec", 32'(halt), 32'h1);
        rchk("level_dec", 32'h8, 32'h1);
        ahb(1'b1, 32'h0, 32'h3);
        i_core.drive(10'h000, 7'h00);
        tk(2);
        chk("halt_enc", 32'(halt), 32'h1);
        rchk("level_enc", 32'h8, 32'h1);
        i_core.drive(10'h100, 7'h00);
        tk(2);
        chk("halt_off", 32'(halt), 32'h0);
        rest;
        rchk("status_clr", 32'hc, 32'h0);
        svc(32'h2, 10'h040, 1'b1);
        svc(32'h2, 10'h041, 1'b0);
        svc(32'h3, 10'h1c0, 1'b1);
        svc(32'h3, 10'h1bf, 1'b0);
        rest;
        $display("t_halt done");
    endtask : t_halt

    task t_fault;
        ahb(1'b1, 32'h0, 32'h3);
        i_core.pulse(10'h100, 7'h20);
        tk(3);
        rchk("fault_enc_uf", 32'hc, 32'h0);
        i_core.pulse(10'h100, 7'h40);
        #1;
        chk("fault_pin", 32'(fault), 32'h1);
        tk(2);
        chk("fault_drop", 32'(fault), 32'h0);
        rchk("fault_sticky", 32'hc, 32'h4);
        ahb(1'b1, 32'hc, 32'h4);
        rchk("fault_w1c", 32'hc, 32'h0);
        ahb(1'b1, 32'h0, 32'h2);
        i_core.pulse(10'h100, 7'h20);
        #1;
        chk("fault_dec_uf", 32'(fault), 32'h1);
        rest;
        $display("t_fault done");
    endtask : t_fault

    task t_irq;
        ahb(1'b1, 32'h10, 32'h10);
        i_core.pulse(10'h100, 7'h10);
        tk(4);
        chk("stats_pin", 32'(stats), 32'h1);
        chk("irq_stats", 32'(irq), 32'h1);
        i_core.pulse(10'h100, 7'h08);
        tk(2);
        chk("stats_clr", 32'(stats), 32'h0);
        chk("irq_sticky", 32'(irq), 32'h1);
        ahb(1'b1, 32'hc, 32'h10);
        tk(3);
        chk("irq_off", 32'(irq), 32'h0);
        ahb(1'b1, 32'h0, 32'h0);
        tk(2);
        chk("irq_low_idle", 32'(irq), 32'h1);
        i_core.pulse(10'h100, 7'h10);
        tk(4);
        chk("irq_low_act", 32'(irq), 32'h0);
        rchk("stats_once", 32'hc, 32'h10);
        i_core.pulse(10'h100, 7'h08);
        rest;
        ahb(1'b1, 32'h10, 32'h20);
        i_core.drive(10'h100, 7'h01);
        tk(4);
        chk("sync_pin", 32'(sync), 32'h1);
        chk("irq_sync", 32'(irq), 32'h1);
        // a live condition must survive a clear of its sticky bit
        ahb(1'b1, 32'hc, 32'h20);
        rchk("sync_relive", 32'hc, 32'h20);
        ahb(1'b1, 32'h10, 32'h0);
        tk(2);
        chk("irq_masked", 32'(irq), 32'h0);
        rest;
        $display("t_irq done");
    endtask : t_irq

    task t_last;
        i_core.pulse(10'h100, 7'h04);
        #1;
        chk("last_set", 32'(last), 32'h1);
        tk(3);
        chk("last_hold", 32'(last), 32'h1);
        i_core.pulse(10'h100, 7'h02);
        #1;
        chk("last_clr", 32'(last), 32'h0);
        // load and read in one cycle: the new final word wins
        i_core.pulse(10'h100, 7'h06);
        #1;
        chk("last_both", 32'(last), 32'h1);
        ahb(1'b1, 32'h10, 32'h3f);
        @(posedge hclk);
        hresetn <= 1'b0;
        tk(2);
        chk("irq_in_reset", 32'(irq), 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        rchk("mask_rerst", 32'h10, 32'h0);
        rchk("mode_rerst", 32'h0, 32'h2);
        $display("t_last done");
    endtask : t_last

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_halt;
        t_fault;
        t_irq;
        t_last;
        tally_and_finish;
    end
endmodule : chs_status_irq_bench
